// >>> src/smwc_pkg.sv
// Package: register map, field layout, wake source coding and timing constants
package smwc_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] SEC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PWR_CFG_ADDR = 8'h04;
  localparam logic [7:0] KBC_CMD_ADDR = 8'h08;
  localparam logic [7:0] KBC_IDLE_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] WAKE_SRC_ADDR = 8'h14;
  // ==========================================================================
  // Secure control fields
  localparam int SC_LOCKOUT_EN = 0;
  localparam int SC_PWR_LOCK_EN = 1;
  localparam int SC_RST_LOCK_EN = 2;
  localparam int SC_VIDEO_EN = 3;
  localparam int SC_FLOPPY_EN = 4;
  localparam int SC_OVERRIDE = 5;
  localparam int SC_WIDTH = 6;
  localparam logic [5:0] SC_RESET = 6'h00;
  // Power configuration fields
  localparam int PC_ACPI_MODE = 0;
  localparam int PC_LEGACY_EN = 1;
  localparam int PC_SRC_LSB = 8;
  // Keyboard controller command bits (write only, act as pulses)
  localparam int KC_ASSERT = 0;
  localparam int KC_DEASSERT = 1;
  localparam int KC_PASSWORD_OK = 2;
  // Idle configuration fields
  localparam int KI_ENABLE = 16;
  localparam int IDLE_W = 16;
  localparam logic [15:0] IDLE_LIMIT_RESET = 16'h0000;
  // ==========================================================================
  // Wake source bit positions
  localparam int WS_SLEEP_BTN = 0;
  localparam int WS_RING1 = 1;
  localparam int WS_RING2 = 2;
  localparam int WS_PME_32 = 3;
  localparam int WS_PME_SEC64 = 4;
  localparam int WS_PME_PRI64 = 5;
  localparam int WS_RTC = 6;
  localparam int WS_MOUSE = 7;
  localparam int WS_KBD = 8;
  localparam int WS_USB = 9;
  localparam int WAKE_SRCS = 10;
  // Sources each state may wake from
  localparam logic [9:0] WAKE_S1_MASK = 10'h1FF;
  localparam logic [9:0] WAKE_S45_MASK = 10'h07E;
  localparam logic [9:0] WAKE_LEGACY_MASK = 10'h06E;
  // Sleep state codes on the state input
  localparam logic [2:0] STATE_S0 = 3'h0;
  localparam logic [2:0] STATE_S1 = 3'h1;
  localparam logic [2:0] STATE_S4 = 3'h4;
  localparam logic [2:0] STATE_S5 = 3'h5;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PRESS_NS = 100;
  localparam int PRESS_CYCLES = (PRESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_TICK_US = 1000;
  localparam int IDLE_TICK_CYCLES = IDLE_TICK_US * 1000000 / CLK_PERIOD_PS;
endpackage

// >>> src/smwc_link_if.sv
// Interface: carries the synchronised lock request and idle expiry to the core
`timescale 1ns/1ps
interface smwc_link_if;
  logic lock_level;
  logic lock_rise;
  logic lock_fall;
  logic idle_expired;
  modport sync_src (output lock_level, output lock_rise, output lock_fall);
  modport timer_src (output idle_expired);
  modport core (input lock_level, input lock_rise, input lock_fall, input idle_expired);
endinterface

// >>> src/smwc_sync.sv
// Two-stage synchroniser with registered edge pulses for the lock request
`timescale 1ns/1ps
module smwc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw level
  input wire logic raw_in,
  // Synchronised level and edges
  smwc_link_if.sync_src link
);
  logic meta;
  logic stable;

  // ==========================================================================
  // Only the second stage reads the first stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta <= raw_in;
      stable <= meta;
    end
  end

  // Level and one-cycle edges, all taken from the second stage onward
  always_ff @(posedge clk) begin
    if (rst) begin
      link.lock_level <= 1'b0;
      link.lock_rise <= 1'b0;
      link.lock_fall <= 1'b0;
    end else begin
      link.lock_level <= stable;
      link.lock_rise <= stable & ~link.lock_level;
      link.lock_fall <= ~stable & link.lock_level;
    end
  end
endmodule // smwc_sync

// >>> src/smwc_idle_timer.sv
// Keyboard and mouse inactivity timer counting slow ticks
`timescale 1ns/1ps
module smwc_idle_timer #(
  parameter int LIMIT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic tick,
  input wire logic activity,
  input wire logic [LIMIT_W-1:0] limit,
  // Expiry pulse
  smwc_link_if.timer_src link
);
  logic [LIMIT_W-1:0] count;
  logic fired;

  if (LIMIT_W < 1 || LIMIT_W > 31) begin : g_bad_width
    $error("smwc_idle_timer: LIMIT_W out of range");
  end

  // ==========================================================================
  // Any activity restarts the count; ticks count only while both are idle
  always_ff @(posedge clk) begin
    if (rst || !enable || activity) begin
      count <= '0;
      fired <= 1'b0;
      link.idle_expired <= 1'b0;
    end else begin
      link.idle_expired <= 1'b0;
      if (tick && !fired) begin
        if (count + 1'b1 >= limit) begin
          fired <= 1'b1;  // Fire once per idle period
          link.idle_expired <= 1'b1;
        end
        count <= count + 1'b1;
      end
    end
  end
endmodule // smwc_idle_timer

// >>> src/smwc_top.sv
// Secure-mode actions, keyboard inactivity lock and wake-source control
`timescale 1ns/1ps

// What this block does
// - Secure lock ignores configured reset button, and power button in S0 only
// - Lock request release unlocks the buttons
// - Blank video on lock assertion if enabled
// - Write-protect floppies on lock assertion if enabled
// - Lock release restores video and floppy writes
// - Separate enables per action and button
// - Override activates enabled actions regardless of request
// - Host commands assert or deassert lock request
// - Both idle past time-out: password, lock
// - ACPI mode wakes per sleep-state table
// - Legacy wake uses firmware-enabled allowed sources
// - Power button always wakes; wake synthesizes press
// - Legacy wake disabled after reset

module smwc_top #(
  parameter int TICK_CYCLES = smwc_pkg::IDLE_TICK_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Lock request as seen on the board wire
  input wire logic SECURE_LOCK_SENSE,
  output logic SECURE_LOCK_REQUEST,
  output logic KBD_PASSWORD_ACTIVE,
  // Keyboard and mouse activity
  input wire logic KBD_ACTIVITY,
  input wire logic MOUSE_ACTIVITY,
  // Front-panel buttons in and toward the chipset
  input wire logic PWR_BTN_IN,
  input wire logic RST_BTN_IN,
  output logic PWR_BTN_OUT,
  output logic RST_BTN_OUT,
  // Secure actions
  output logic VIDEO_BLANK,
  output logic FLOPPY_WP,
  // Wake sources and system state
  input wire logic [2:0] SLEEP_STATE,
  input wire logic [9:0] WAKE_EVENTS,
  input wire logic MGMT_WAKE
);
  // ==========================================================================
  // Declarations
  smwc_link_if link ();

  // Configuration registers
  logic [smwc_pkg::SC_WIDTH-1:0] sec_ctrl;
  logic acpi_mode;
  logic legacy_en;
  logic [smwc_pkg::WAKE_SRCS-1:0] legacy_src;
  logic idle_en;
  logic [smwc_pkg::IDLE_W-1:0] idle_limit;

  // Wake path
  logic [smwc_pkg::WAKE_SRCS-1:0] wake_src;
  logic [smwc_pkg::WAKE_SRCS-1:0] events_prev;
  logic [smwc_pkg::WAKE_SRCS-1:0] wake_edges;
  logic [smwc_pkg::WAKE_SRCS-1:0] wake_hits;
  logic mgmt_prev;

  // Tick and press timing
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
  logic tick;
  logic [$clog2(smwc_pkg::PRESS_CYCLES+1)-1:0] press_cnt;
  logic press_active;

  // Secure actions
  logic secure_eff;
  logic awake;
  logic video_latch;
  logic floppy_latch;
  logic pwr_locked;
  logic rst_locked;

  // Decode helpers
  logic cmd_write;
  logic next_wake;

  // Elaboration check: the tick counter needs two states
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("smwc_top: TICK_CYCLES must be at least 2");
  end

  // ==========================================================================
  // Decoding of wake permission, used by the wake path only
  function automatic logic [9:0] wake_allow(input logic acpi, input logic leg_en,
                                            input logic [9:0] leg_src, input logic [2:0] state);
    logic [9:0] mask;
    mask = 10'h000;
    if (acpi) begin
      if (state == smwc_pkg::STATE_S1) mask = smwc_pkg::WAKE_S1_MASK;
      else if (state == smwc_pkg::STATE_S4 || state == smwc_pkg::STATE_S5) mask = smwc_pkg::WAKE_S45_MASK;
    end else if (leg_en && state != smwc_pkg::STATE_S0) begin
      mask = leg_src & smwc_pkg::WAKE_LEGACY_MASK;
    end
    // In ACPI mode any other state wakes nothing; legacy mode wakes in every state but S0
    return mask;
  endfunction

  // ==========================================================================
  // Submodules
  // Lock wire enters through two flops
  smwc_sync u_sync (
    .clk(MCLK),
    .rst(SRST),
    .raw_in(SECURE_LOCK_SENSE),
    .link(link.sync_src)
  );

  // Idle timer paced by the slow tick
  smwc_idle_timer #(
    .LIMIT_W(smwc_pkg::IDLE_W)
  ) u_idle (
    .clk(MCLK),
    .rst(SRST),
    .enable(idle_en),
    .tick(tick),
    .activity(KBD_ACTIVITY | MOUSE_ACTIVITY),
    .limit(idle_limit),
    .link(link.timer_src)
  );

  // ==========================================================================
  // Slow tick for the inactivity timer
  // One cycle wide, so each tick counts once
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == $bits(tick_cnt)'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Register writes
  // Unmapped writes change nothing
  assign cmd_write = WR && (ADDR == smwc_pkg::KBC_CMD_ADDR);

  // Secure action enables and override, each bit separate
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sec_ctrl <= smwc_pkg::SC_RESET;
    end else if (WR && ADDR == smwc_pkg::SEC_CTRL_ADDR) begin
      sec_ctrl <= WDATA[smwc_pkg::SC_WIDTH-1:0];
    end
  end

  // Power mode and legacy wake sources; legacy wake starts disabled
  // Source bits are masked again where used
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      acpi_mode <= 1'b0;
      legacy_en <= 1'b0;
      legacy_src <= '0;
    end else if (WR && ADDR == smwc_pkg::PWR_CFG_ADDR) begin
      acpi_mode <= WDATA[smwc_pkg::PC_ACPI_MODE];
      legacy_en <= WDATA[smwc_pkg::PC_LEGACY_EN];
      legacy_src <= WDATA[smwc_pkg::PC_SRC_LSB +: smwc_pkg::WAKE_SRCS];
    end
  end

  // Inactivity configuration; firmware writes it only once a password exists
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      idle_en <= 1'b0;
      idle_limit <= smwc_pkg::IDLE_LIMIT_RESET;
    end else if (WR && ADDR == smwc_pkg::KBC_IDLE_ADDR) begin
      idle_en <= WDATA[smwc_pkg::KI_ENABLE];
      idle_limit <= WDATA[smwc_pkg::IDLE_W-1:0];
    end
  end

  // ==========================================================================
  // Keyboard controller side: lock request driven onto the board wire
  // Expiry beats a deassert command in the same cycle so no lock is lost
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      SECURE_LOCK_REQUEST <= 1'b0;
    end else if (link.idle_expired || (cmd_write && WDATA[smwc_pkg::KC_ASSERT])) begin
      SECURE_LOCK_REQUEST <= 1'b1;
    end else if (cmd_write && WDATA[smwc_pkg::KC_DEASSERT]) begin
      SECURE_LOCK_REQUEST <= 1'b0;
    end
  end

  // Keyboard password engaged on expiry, released when host accepts it
  // Expiry wins over an acceptance in the same cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      KBD_PASSWORD_ACTIVE <= 1'b0;
    end else if (link.idle_expired) begin
      KBD_PASSWORD_ACTIVE <= 1'b1;
    end else if (cmd_write && WDATA[smwc_pkg::KC_PASSWORD_OK]) begin
      KBD_PASSWORD_ACTIVE <= 1'b0;
    end
  end

  // ==========================================================================
  // Secure actions, driven from the synchronised request and the override bit
  assign secure_eff = link.lock_level | sec_ctrl[smwc_pkg::SC_OVERRIDE];
  assign awake = (SLEEP_STATE == smwc_pkg::STATE_S0);

  // Lockout is a level: it follows the request both ways
  // Power lockout only applied while running, so a locked power button can still wake a sleeper; reset lockout applies in every state
  assign pwr_locked = awake & secure_eff & sec_ctrl[smwc_pkg::SC_LOCKOUT_EN]
                      & sec_ctrl[smwc_pkg::SC_PWR_LOCK_EN];
  assign rst_locked = secure_eff & sec_ctrl[smwc_pkg::SC_LOCKOUT_EN]
                      & sec_ctrl[smwc_pkg::SC_RST_LOCK_EN];

  // Video and floppy act on the request becoming asserted, not on its level,
  // so enabling the option mid-lock waits for the next assertion
  always_ff @(posedge MCLK) begin
    if (SRST || !sec_ctrl[smwc_pkg::SC_VIDEO_EN] || link.lock_fall) begin
      video_latch <= 1'b0;
    end else if (link.lock_rise) begin
      video_latch <= 1'b1;
    end
  end

  // Floppy protection latches the same way
  always_ff @(posedge MCLK) begin
    if (SRST || !sec_ctrl[smwc_pkg::SC_FLOPPY_EN] || link.lock_fall) begin
      floppy_latch <= 1'b0;
    end else if (link.lock_rise) begin
      floppy_latch <= 1'b1;
    end
  end

  // Registered outputs; override gated by each enable
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      VIDEO_BLANK <= 1'b0;
      FLOPPY_WP <= 1'b0;
    end else begin
      VIDEO_BLANK <= sec_ctrl[smwc_pkg::SC_VIDEO_EN]
                     & (video_latch | sec_ctrl[smwc_pkg::SC_OVERRIDE]);
      FLOPPY_WP <= sec_ctrl[smwc_pkg::SC_FLOPPY_EN]
                   & (floppy_latch | sec_ctrl[smwc_pkg::SC_OVERRIDE]);
    end
  end

  // ==========================================================================
  // Wake detection on rising edges of the sources
  // A held source wakes only once
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      events_prev <= '0;
      mgmt_prev <= 1'b0;
    end else begin
      events_prev <= WAKE_EVENTS;
      mgmt_prev <= MGMT_WAKE;
    end
  end

  assign wake_edges = WAKE_EVENTS & ~events_prev;
  assign wake_hits = wake_edges & wake_allow(acpi_mode, legacy_en, legacy_src, SLEEP_STATE);

  // Management wake request is turned into a press in any state but S0, whatever the wake mode
  assign next_wake = !awake && ((|wake_hits) || (MGMT_WAKE && !mgmt_prev));

  // Last wake cause for software; the sources keep their own status
  // A press in progress keeps the first cause
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wake_src <= '0;
    end else if (next_wake && !press_active) begin
      wake_src <= wake_hits;
    end else if (WR && ADDR == smwc_pkg::WAKE_SRC_ADDR) begin
      wake_src <= '0;
    end
  end

  // Synthesized press of fixed length; new wakes during a press merge into it
  // Length comes from the package
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      press_cnt <= '0;
      press_active <= 1'b0;
    end else if (next_wake && !press_active) begin
      press_cnt <= $bits(press_cnt)'(smwc_pkg::PRESS_CYCLES - 1);
      press_active <= 1'b1;
    end else if (press_active) begin
      if (press_cnt == '0) press_active <= 1'b0;
      else press_cnt <= press_cnt - 1'b1;
    end
  end

  // ==========================================================================
  // Buttons toward the chipset
  // Asleep, a real power button press always passes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PWR_BTN_OUT <= 1'b0;
      RST_BTN_OUT <= 1'b0;
    end else begin
      PWR_BTN_OUT <= (PWR_BTN_IN & ~pwr_locked) | press_active;
      RST_BTN_OUT <= RST_BTN_IN & ~rst_locked;
    end
  end

  // ==========================================================================
  // Register reads, data in the cycle after the strobe; unmapped reads zero
  // Reads have no side effects
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      unique case (ADDR)
        smwc_pkg::SEC_CTRL_ADDR: RDATA <= {26'h000_0000, sec_ctrl};
        smwc_pkg::PWR_CFG_ADDR: RDATA <= {14'h0000, legacy_src, 6'h00, legacy_en, acpi_mode};
        smwc_pkg::KBC_CMD_ADDR: RDATA <= {30'h0000_0000, KBD_PASSWORD_ACTIVE, SECURE_LOCK_REQUEST};
        smwc_pkg::KBC_IDLE_ADDR: RDATA <= {15'h0000, idle_en, idle_limit};
        smwc_pkg::STATUS_ADDR: RDATA <= {24'h00_0000, press_active, rst_locked, pwr_locked,
                                         FLOPPY_WP, VIDEO_BLANK, secure_eff, link.lock_level,
                                         acpi_mode};
        smwc_pkg::WAKE_SRC_ADDR: RDATA <= {22'h00_0000, wake_src};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule // smwc_top

// >>> dv/smwc_top_checker.sv
// Checker: port-level timing relations of the secure-mode and wake block
`timescale 1ns/1ps
module smwc_top_checker #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Lock and buttons
  input wire logic SECURE_LOCK_SENSE,
  input wire logic SECURE_LOCK_REQUEST,
  input wire logic KBD_PASSWORD_ACTIVE,
  input wire logic PWR_BTN_IN,
  input wire logic RST_BTN_IN,
  input wire logic PWR_BTN_OUT,
  input wire logic RST_BTN_OUT,
  input wire logic VIDEO_BLANK,
  input wire logic FLOPPY_WP,
  // Wake
  input wire logic [2:0] SLEEP_STATE,
  input wire logic [9:0] WAKE_EVENTS,
  input wire logic MGMT_WAKE
);
  // ==========================================================================
  // Helpers
  logic wr_sec;
  assign wr_sec = WR && (ADDR == smwc_pkg::SEC_CTRL_ADDR);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // ==========================================================================
  // Assertions
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data not zero outside the answer cycle");
  a_rst_btn_gated: assert property (RST_BTN_OUT |-> $past(RST_BTN_IN))
    else $error("reset button output without a pressed input");
  a_video_has_cause: assert property ($rose(VIDEO_BLANK) |->
    $past(SECURE_LOCK_SENSE, 4) || $past(SECURE_LOCK_SENSE, 5) || $past(wr_sec, 1) || $past(wr_sec, 2))
    else $error("video blank rose without a lock or override");
  a_floppy_has_cause: assert property ($rose(FLOPPY_WP) |->
    $past(SECURE_LOCK_SENSE, 4) || $past(SECURE_LOCK_SENSE, 5) || $past(wr_sec, 1) || $past(wr_sec, 2))
    else $error("floppy protect rose without a lock or override");
  a_cmd_sets_lock: assert property (WR && ADDR == smwc_pkg::KBC_CMD_ADDR && WDATA[smwc_pkg::KC_ASSERT]
    |=> SECURE_LOCK_REQUEST)
    else $error("assert command did not raise the lock request");
  a_password_with_lock: assert property ($rose(KBD_PASSWORD_ACTIVE) |-> SECURE_LOCK_REQUEST)
    else $error("password engaged without a lock request");
  a_mgmt_wake_press: assert property ($rose(MGMT_WAKE) && SLEEP_STATE != smwc_pkg::STATE_S0 && !PWR_BTN_OUT
    |-> ##2 PWR_BTN_OUT)
    else $error("management wake gave no power press");
  a_no_wake_awake: assert property ($rose(PWR_BTN_OUT) |->
    $past(PWR_BTN_IN) || ($past(SLEEP_STATE, 2) != smwc_pkg::STATE_S0))
    else $error("power press appeared while awake with no button");
  a_press_min_len: assert property ($rose(PWR_BTN_OUT) && !$past(PWR_BTN_IN) |-> PWR_BTN_OUT [*8])
    else $error("synthesized press too short");
endmodule // smwc_top_checker

bind smwc_top smwc_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SECURE_LOCK_SENSE(SECURE_LOCK_SENSE), .SECURE_LOCK_REQUEST(SECURE_LOCK_REQUEST),
  .KBD_PASSWORD_ACTIVE(KBD_PASSWORD_ACTIVE), .PWR_BTN_IN(PWR_BTN_IN), .RST_BTN_IN(RST_BTN_IN),
  .PWR_BTN_OUT(PWR_BTN_OUT), .RST_BTN_OUT(RST_BTN_OUT), .VIDEO_BLANK(VIDEO_BLANK), .FLOPPY_WP(FLOPPY_WP),
  .SLEEP_STATE(SLEEP_STATE), .WAKE_EVENTS(WAKE_EVENTS), .MGMT_WAKE(MGMT_WAKE));

// >>> dv/smwc_kbc_model.sv
// Board model: keyboard controller lock wire looped back to the sense pin
`timescale 1ns/1ps
module smwc_kbc_model (
  // Clock
  input wire logic clk,
  // Lock request from the controller
  input wire logic request,
  // Bench takeover of the wire
  input wire logic drive_en,
  input wire logic drive_val,
  // Wire as seen at the sense pin
  output logic sense
);
  // One cycle of wire delay, so the sense never moves in the request's own cycle
  always_ff @(posedge clk) begin
    sense <= drive_en ? drive_val : request;
  end
endmodule // smwc_kbc_model

// >>> dv/tb.sv
// Self-checking testbench for the secure-mode and wake control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  // ==========================================================================
  // Signals
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic sense, lock_req, pwd, pwr_out, rst_out, video, floppy;
  logic kbd_act = 1'b0;
  logic mouse_act = 1'b0;
  logic pwr_in = 1'b0;
  logic rst_in = 1'b0;
  logic [2:0] sleep_state = 3'h0;
  logic [9:0] wake_ev = 10'h000;
  logic mgmt_wake = 1'b0;
  logic drive_en = 1'b0;
  logic drive_val = 1'b0;
  logic exp;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] cfg [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0003_FF02};
  logic [2:0] st [4] = '{smwc_pkg::STATE_S0, smwc_pkg::STATE_S1, smwc_pkg::STATE_S4, smwc_pkg::STATE_S5};
  // 250 MHz clock
  always #2 mclk = ~mclk;
  // ==========================================================================
  // Design and board model
  smwc_top #(.TICK_CYCLES(4)) dut (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SECURE_LOCK_SENSE(sense), .SECURE_LOCK_REQUEST(lock_req), .KBD_PASSWORD_ACTIVE(pwd),
    .KBD_ACTIVITY(kbd_act), .MOUSE_ACTIVITY(mouse_act), .PWR_BTN_IN(pwr_in), .RST_BTN_IN(rst_in),
    .PWR_BTN_OUT(pwr_out), .RST_BTN_OUT(rst_out), .VIDEO_BLANK(video), .FLOPPY_WP(floppy),
    .SLEEP_STATE(sleep_state), .WAKE_EVENTS(wake_ev), .MGMT_WAKE(mgmt_wake));
  smwc_kbc_model kbc (.clk(mclk), .request(lock_req), .drive_en(drive_en), .drive_val(drive_val), .sense(sense));
  // ==========================================================================
  // Access tasks
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge mclk); wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk); addr <= a; rd <= 1'b1;
    @(posedge mclk); rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Allowed wake sources per mode and state, from the wake table
  function automatic logic allowed(input int m, input logic [2:0] s, input int b);
    logic [9:0] s1_set = 10'h1FF;
    logic [9:0] s45_set = 10'h07E;
    logic [9:0] leg_set = 10'h06E;
    if (m == 0 || s == smwc_pkg::STATE_S0) return 1'b0;
    if (m == 2) return leg_set[b];
    return (s == smwc_pkg::STATE_S1) ? s1_set[b] : s45_set[b];
  endfunction
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Watchdog, well above the expected run of some 4.7k cycles
  initial begin
    #160000;
    n_fail++;
    results();
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("sec_ctrl", smwc_pkg::SEC_CTRL_ADDR, 32'h0000_0000);
    rd_chk("pwr_cfg", smwc_pkg::PWR_CFG_ADDR, 32'h0000_0000);
    rd_chk("status", smwc_pkg::STATUS_ADDR, 32'h0000_0000);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    $display("test reset done");
    // Full lockout with every action enabled
    @(posedge mclk); pwr_in <= 1'b1; rst_in <= 1'b1;
    wr_reg(smwc_pkg::SEC_CTRL_ADDR, 32'h0000_001F);
    cyc(3);
    `CHK("rst_out open", 1'b1, rst_out)
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0001);
    cyc(8);
    `CHK("lock_req", 1'b1, lock_req)
    `CHK("pwr_out locked", 1'b0, pwr_out)
    `CHK("rst_out locked", 1'b0, rst_out)
    `CHK("video", 1'b1, video)
    `CHK("floppy", 1'b1, floppy)
    rd_chk("kbc_cmd", smwc_pkg::KBC_CMD_ADDR, 32'h0000_0001);
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0002);
    cyc(8);
    `CHK("pwr_out free", 1'b1, pwr_out)
    `CHK("rst_out free", 1'b1, rst_out)
    `CHK("video off", 1'b0, video)
    `CHK("floppy off", 1'b0, floppy)
    $display("test lockout done");
    // Reset button alone locked, other actions off
    wr_reg(smwc_pkg::SEC_CTRL_ADDR, 32'h0000_0005);
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0001);
    cyc(8);
    `CHK("pwr_out per button", 1'b1, pwr_out)
    `CHK("rst_out per button", 1'b0, rst_out)
    `CHK("video disabled", 1'b0, video)
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0002);
    cyc(8);
    // Wire driven directly: gating must lag the raw edge
    @(posedge mclk); drive_en <= 1'b1; drive_val <= 1'b1;
    cyc(2);
    `CHK("rst_out before sync", 1'b1, rst_out)
    cyc(6);
    `CHK("rst_out after sync", 1'b0, rst_out)
    @(posedge mclk); drive_val <= 1'b0;
    cyc(8);
    `CHK("rst_out released", 1'b1, rst_out)
    $display("test per button done");
    // Override with the wire low
    wr_reg(smwc_pkg::SEC_CTRL_ADDR, 32'h0000_003F);
    cyc(3);
    `CHK("video override", 1'b1, video)
    `CHK("floppy override", 1'b1, floppy)
    `CHK("rst_out override", 1'b0, rst_out)
    wr_reg(smwc_pkg::SEC_CTRL_ADDR, 32'h0000_0000);
    cyc(3);
    `CHK("video override off", 1'b0, video)
    @(posedge mclk); drive_en <= 1'b0; pwr_in <= 1'b0; rst_in <= 1'b0;
    $display("test override done");
    // Idle timer: limit of 3 ticks, firmware has a password set
    wr_reg(smwc_pkg::KBC_IDLE_ADDR, 32'h0001_0003);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk); kbd_act <= ~i[0]; mouse_act <= i[0];
      @(posedge mclk); kbd_act <= 1'b0; mouse_act <= 1'b0;
      cyc(6);
    end
    `CHK("lock_req while active", 1'b0, lock_req)
    cyc(40);
    `CHK("lock_req idle", 1'b1, lock_req)
    `CHK("password idle", 1'b1, pwd)
    wr_reg(smwc_pkg::KBC_IDLE_ADDR, 32'h0000_0000);
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0006);
    cyc(3);
    `CHK("lock_req cleared", 1'b0, lock_req)
    `CHK("password cleared", 1'b0, pwd)
    $display("test idle done");
    // Wake table over modes, states and sources; legacy first left disabled
    for (int m = 0; m < 3; m++) begin
      wr_reg(smwc_pkg::PWR_CFG_ADDR, cfg[m]);
      for (int s = 0; s < 4; s++) begin
        for (int b = 0; b < 10; b++) begin
          exp = allowed(m, st[s], b);
          @(posedge mclk); sleep_state <= st[s]; wake_ev <= 10'h001 << b;
          cyc(3);
          `CHK("wake press", exp, pwr_out)
          @(posedge mclk); wake_ev <= 10'h000;
          cyc(28);
          rd_chk("wake src", smwc_pkg::WAKE_SRC_ADDR, exp ? (32'h0000_0001 << b) : 32'h0000_0000);
          wr_reg(smwc_pkg::WAKE_SRC_ADDR, 32'h0000_0000);
        end
      end
    end
    $display("test wake table done");
    // Management wake and power button while locked and asleep
    wr_reg(smwc_pkg::PWR_CFG_ADDR, 32'h0000_0001);
    @(posedge mclk); sleep_state <= smwc_pkg::STATE_S4; mgmt_wake <= 1'b1;
    cyc(3);
    `CHK("mgmt press", 1'b1, pwr_out)
    @(posedge mclk); mgmt_wake <= 1'b0;
    cyc(28);
    rd_chk("mgmt src", smwc_pkg::WAKE_SRC_ADDR, 32'h0000_0000);
    wr_reg(smwc_pkg::SEC_CTRL_ADDR, 32'h0000_0003);
    wr_reg(smwc_pkg::KBC_CMD_ADDR, 32'h0000_0001);
    cyc(8);
    @(posedge mclk); pwr_in <= 1'b1;
    cyc(2);
    `CHK("pwr wakes locked", 1'b1, pwr_out)
    @(posedge mclk); pwr_in <= 1'b0; sleep_state <= smwc_pkg::STATE_S0;
    cyc(30);
    $display("test power wake done");
    results();
  end
endmodule // tb
